/* hw/cds_core_decode.sv */
// Instruction splitting, cycle timing and standby/wake control of the core
`timescale 1ns/1ps
`default_nettype none
`include "cds_params.svh"
module cds_core_decode (
  input  wire logic                  ref_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic [13:0]           insn_word_in,
  input  wire logic                  branch_taken_in,
  input  wire logic                  irq_pending_in,
  input  wire logic                  global_irq_enable_in,
  input  wire cds_pkg::cds_osc_type  osc_mode_in,
  output logic [1:0]                 phase_out,
  output logic                       insn_fetch_out,
  output cds_pkg::cds_class_type     insn_class_out,
  output logic [5:0]                 opcode_out,
  output logic [6:0]                 file_addr_out,
  output logic                       dest_file_out,
  output logic [2:0]                 bit_sel_out,
  output logic [7:0]                 literal8_out,
  output logic [10:0]                literal11_out,
  output logic                       exec_nop_out,
  output logic                       sleep_active_out,
  output logic                       osc_drive_on_out,
  output logic                       watchdog_counter_clear_out,
  output logic                       timeout_flag_n_out,
  output logic                       powerdown_flag_n_out,
  output logic                       vector_irq_out,
  output logic [12:0]                vector_addr_out
);
  import cds_pkg::*;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  function automatic cds_class_type class_of(input logic [13:0] w);
    case (w[13:12])
      2'h0:    class_of = CDS_CLASS_BYTE;
      2'h1:    class_of = CDS_CLASS_BIT;
      2'h2:    class_of = CDS_CLASS_JUMP;
      default: class_of = CDS_CLASS_LIT;
    endcase
  endfunction : class_of

  // Don't-care bits (e.g. no-op bits 6:5) are masked before compare
  function automatic logic is_word(input logic [13:0] w, input logic [13:0] ref_w);
    is_word = ((w & `CDS_NOP_MASK) == (ref_w & `CDS_NOP_MASK));
  endfunction : is_word

  cds_class_type next_class;
  wire logic [6:0]  next_file  = insn_word_in[`CDS_F_MSB:0];
  wire logic        next_dest  = insn_word_in[`CDS_D_POS];
  wire logic [2:0]  next_bit   = insn_word_in[`CDS_B_LSB+2:`CDS_B_LSB];
  wire logic [7:0]  next_lit8  = insn_word_in[7:0];
  wire logic [10:0] next_lit11 = insn_word_in[10:0];
  wire logic [5:0]  next_op    = insn_word_in[13:8];
  wire logic        is_sleep   = is_word(insn_word_in, `CDS_SLEEP_WORD);
  wire logic        is_clrwdt  = is_word(insn_word_in, `CDS_CLRWDT_WORD);
  wire logic        is_ret     = is_word(insn_word_in, `CDS_RETURN_WORD) |
                                 is_word(insn_word_in, `CDS_RETFIE_WORD);
  wire logic        is_two     = (next_class == CDS_CLASS_JUMP) | is_ret |
                                 (insn_word_in[13:10] == 4'hD);
  assign next_class = class_of(insn_word_in);

  // ----------------------------------------------------------------
  // Phase and state control
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CDS_ST_RUN,
    CDS_ST_SLEEP,
    CDS_ST_OST
  } cds_state_type;

  cds_state_type state;
  logic [10:0]   ost_count;
  logic          stall_nop;
  logic          wake_vector_pend;

  wire logic cycle_end  = (phase_out == 2'h3);
  wire logic running    = (state == CDS_ST_RUN);
  wire logic issue      = running & cycle_end;
  wire logic need_ost   = (osc_mode_in != CDS_OSC_RC);
  // Sleep is skipped when a wake source is already pending
  wire logic sleep_go   = issue & !stall_nop & is_sleep & !irq_pending_in;
  wire logic wake       = (state == CDS_ST_SLEEP) & irq_pending_in;
  wire logic ost_done   = (ost_count == 11'(`CDS_OST_CYCLES - 1));

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state     <= CDS_ST_RUN;
      ost_count <= 11'h000;
    end else begin
      case (state)
        CDS_ST_RUN:   if (sleep_go) state <= CDS_ST_SLEEP;
        CDS_ST_SLEEP: if (wake) state <= need_ost ? CDS_ST_OST : CDS_ST_RUN;
        CDS_ST_OST:   if (ost_done) state <= CDS_ST_RUN;
        default:      state <= CDS_ST_RUN;
      endcase
      ost_count <= (state == CDS_ST_OST) ? ost_count + 11'h001 : 11'h000;
    end
  end

  // Phase is frozen outside run and restarts at the first phase on wake
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) phase_out <= 2'h0;
    else if (!running) phase_out <= 2'h0;
    else phase_out <= phase_out + 2'h1;
  end

  // ----------------------------------------------------------------
  // Latched instruction fields
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      insn_class_out <= CDS_CLASS_BYTE;
      opcode_out     <= 6'h00;
      file_addr_out  <= 7'h00;
      dest_file_out  <= 1'b0;
      bit_sel_out    <= 3'h0;
      literal8_out   <= 8'h00;
      literal11_out  <= 11'h000;
      exec_nop_out   <= 1'b0;
      stall_nop      <= 1'b0;
      insn_fetch_out <= 1'b0;
    end else begin
      insn_fetch_out <= issue;
      if (issue) begin
        insn_class_out <= next_class;
        opcode_out     <= next_op;
        file_addr_out  <= next_file;
        dest_file_out  <= next_dest;
        bit_sel_out    <= next_bit;
        literal8_out   <= next_lit8;
        literal11_out  <= next_lit11;
        exec_nop_out   <= stall_nop;
        // A taken skip or a flow change flushes the next fetch
        stall_nop      <= !stall_nop & (is_two | branch_taken_in);
      end
    end
  end

  // ----------------------------------------------------------------
  // Standby flags, watchdog clear and wake vectoring
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timeout_flag_n_out         <= `CDS_FLAG_RESET;
      powerdown_flag_n_out       <= `CDS_FLAG_RESET;
      watchdog_counter_clear_out <= 1'b0;
      sleep_active_out           <= 1'b0;
      osc_drive_on_out           <= 1'b1;
      wake_vector_pend           <= 1'b0;
      vector_irq_out             <= 1'b0;
      vector_addr_out            <= 13'h0000;
    end else begin
      watchdog_counter_clear_out <= sleep_go | (issue & !stall_nop & is_clrwdt);
      if (sleep_go | (issue & !stall_nop & is_clrwdt)) begin
        timeout_flag_n_out   <= 1'b1;
        powerdown_flag_n_out <= !sleep_go;
      end
      sleep_active_out <= (state == CDS_ST_SLEEP) ? !wake : sleep_go;
      osc_drive_on_out <= (state == CDS_ST_SLEEP) ? wake : !sleep_go;
      if (wake) wake_vector_pend <= global_irq_enable_in;
      else if (issue && wake_vector_pend) wake_vector_pend <= 1'b0;
      // Vector only after the prefetched word has been issued
      vector_irq_out  <= issue & wake_vector_pend;
      vector_addr_out <= `CDS_IRQ_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_phase_wraps: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    running && phase_out == 2'h3 |=> phase_out == 2'h0 || !running) else $error("phase wrap wrong");
  a_sleep_flags: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    sleep_go |=> !powerdown_flag_n_out && timeout_flag_n_out && watchdog_counter_clear_out)
    else $error("standby flags wrong");
  a_pending_nop: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    issue && is_sleep && irq_pending_in |=> $stable(powerdown_flag_n_out) && state == CDS_ST_RUN)
    else $error("standby not skipped");
  a_wake_rc: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wake && !need_ost |=> state == CDS_ST_RUN && phase_out == 2'h0) else $error("rc wake slow");
  a_wake_ost: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wake && need_ost |=> state == CDS_ST_OST [*8]) else $error("start-up delay cut");
  a_skip_nop: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    issue && !stall_nop && is_two |-> ##4 issue ##1 exec_nop_out) else $error("no second cycle");
  a_wake_flags: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    state == CDS_ST_SLEEP |-> !powerdown_flag_n_out && timeout_flag_n_out) else $error("sleep flags");
  a_osc_off: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    state == CDS_ST_SLEEP && !$past(wake) |-> !osc_drive_on_out) else $error("osc on in standby");
  a_fetch_pulse: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    issue |=> insn_fetch_out ##1 !insn_fetch_out) else $error("fetch pulse wrong");
  a_nop_single: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    issue && stall_nop |=> exec_nop_out && !stall_nop) else $error("no-op repeated");
  a_wake_vector: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    wake |=> wake_vector_pend == $past(global_irq_enable_in)) else $error("vector intent lost");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_sleep: cover property (@(posedge ref_clk_in) sleep_go);
  c_wake_vec: cover property (@(posedge ref_clk_in) vector_irq_out);
  c_pending: cover property (@(posedge ref_clk_in) issue && is_sleep && irq_pending_in);
  c_ost_done: cover property (@(posedge ref_clk_in) state == CDS_ST_OST && ost_done);
endmodule : cds_core_decode
`default_nettype wire

/* hw/cds_params.svh */
// Constants for the instruction decode and standby control block
`ifndef CDS_PARAMS_SVH
`define CDS_PARAMS_SVH
`define CDS_INSN_W        14
`define CDS_PHASES        4
`define CDS_OST_TOSC      1024
`define CDS_OST_CYCLES    (`CDS_OST_TOSC)
`define CDS_IRQ_VECTOR    13'h0004
`define CDS_SLEEP_WORD    14'h0063
`define CDS_CLRWDT_WORD   14'h0064
`define CDS_RETFIE_WORD   14'h0009
`define CDS_RETURN_WORD   14'h0008
`define CDS_NOP_MASK      14'h3F9F
`define CDS_F_MSB         6
`define CDS_D_POS         7
`define CDS_B_LSB         7
`define CDS_FLAG_RESET    1'b1
`endif

/* hw/cds_pkg.sv */
// Types shared by the decode and standby block
package cds_pkg;
  typedef enum logic [1:0] {
    CDS_CLASS_BYTE,
    CDS_CLASS_BIT,
    CDS_CLASS_JUMP,
    CDS_CLASS_LIT
  } cds_class_type;
  typedef enum logic [1:0] {
    CDS_OSC_LP,
    CDS_OSC_XT,
    CDS_OSC_HS,
    CDS_OSC_RC
  } cds_osc_type;
endpackage : cds_pkg

/* verif/cds_prog_mem.sv */
// Program memory model feeding instruction words to the decode block
`timescale 1ns/1ps
`default_nettype none
module cds_prog_mem (
  input  wire logic [1:0]  phase_in,
  input  wire logic [13:0] next_word_in,
  output logic [13:0]      insn_word_out
);
  // ----------------------------------------
  // Word presentation
  // ----------------------------------------
  // Valid only in the issue phase; the inverse elsewhere catches sampling in the wrong phase
  assign insn_word_out = (phase_in == 2'h3) ? next_word_in : ~next_word_in;
endmodule : cds_prog_mem
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the decode and standby block
`timescale 1ns/1ps
`default_nettype none
`include "cds_params.svh"
module tb;
  import cds_pkg::*;
  logic          ref_clk_in = 1'b0;
  logic          reset_n_in = 1'b0;
  logic [13:0]   next_word  = 14'h0000;
  logic          branch     = 1'b0;
  logic          irq        = 1'b0;
  logic          global_irq_enable        = 1'b0;
  cds_osc_type   osc_mode   = CDS_OSC_RC;
  logic [13:0]   insn_word;
  logic [1:0]    phase;
  logic          fetch, dest, nop, slp, osc_on, wdt_clr, to_n, pd_n, vec;
  cds_class_type cls;
  logic [5:0]    opc;
  logic [6:0]    faddr;
  logic [2:0]    bsel;
  logic [7:0]    lit8;
  logic [10:0]   lit11;
  logic [12:0]   vaddr;
  int            errors = 0, checked = 0, wdt_cnt = 0, vec_cnt = 0;

  always #50 ref_clk_in = ~ref_clk_in;
  // Pulses are counted so scenarios can judge how many occurred
  always @(negedge ref_clk_in) begin
    if (wdt_clr === 1'b1) wdt_cnt++;
    if (vec === 1'b1) vec_cnt++;
  end

  cds_prog_mem u_mem (.phase_in(phase), .next_word_in(next_word), .insn_word_out(insn_word));
  cds_core_decode u_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .insn_word_in(insn_word),
    .branch_taken_in(branch), .irq_pending_in(irq), .global_irq_enable_in(global_irq_enable), .osc_mode_in(osc_mode),
    .phase_out(phase), .insn_fetch_out(fetch), .insn_class_out(cls), .opcode_out(opc),
    .file_addr_out(faddr), .dest_file_out(dest), .bit_sel_out(bsel), .literal8_out(lit8),
    .literal11_out(lit11), .exec_nop_out(nop), .sleep_active_out(slp), .osc_drive_on_out(osc_on),
    .watchdog_counter_clear_out(wdt_clr), .timeout_flag_n_out(to_n), .powerdown_flag_n_out(pd_n),
    .vector_irq_out(vec), .vector_addr_out(vaddr));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // Three negedges after the issue edge keep successive issues back to back
  task automatic issue(input logic [13:0] w, input logic br, output logic nop_seen);
    int n;
    n = 0;
    @(negedge ref_clk_in);
    while (phase !== 2'h3 && n < 2000) begin
      @(negedge ref_clk_in);
      n++;
    end
    next_word = w;
    branch = br;
    n = 0;
    repeat (3) begin
      @(negedge ref_clk_in);
      branch = 1'b0;
      check(fetch, (n == 0) ? 16'h0001 : 16'h0000);
      n++;
    end
    nop_seen = (nop === 1'b1);
  endtask : issue

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_phase;
    logic [1:0] p;
    @(negedge ref_clk_in);
    p = phase;
    repeat (8) begin
      @(negedge ref_clk_in);
      p = p + 2'h1;
      check(phase, p);
    end
  endtask : t_phase

  task automatic t_fields;
    logic n;
    issue(14'h07D5, 1'b0, n);
    check(opc, 6'h07);
    check(cls, CDS_CLASS_BYTE);
    check({faddr, dest}, {7'h55, 1'b1});
    issue(14'h077F, 1'b0, n);
    check({faddr, dest}, {7'h7F, 1'b0});
    issue(14'h1692, 1'b0, n);
    check({cls, faddr, bsel}, {CDS_CLASS_BIT, 7'h12, 3'h5});
    issue(14'h30A5, 1'b0, n);
    check({cls, lit8}, {CDS_CLASS_LIT, 8'hA5});
    issue(14'h33A5, 1'b0, n);
    check({cls, lit8}, {CDS_CLASS_LIT, 8'hA5});
    issue(14'h2DA3, 1'b0, n);
    check({cls, lit11}, {CDS_CLASS_JUMP, 11'h5A3});
    issue(14'h0000, 1'b0, n);
    check(n, 1'b1);
    issue(14'h0000, 1'b0, n);
    check(n, 1'b0);
    issue(14'h0B55, 1'b1, n);
    issue(14'h0000, 1'b0, n);
    check(n, 1'b1);
    issue(`CDS_RETURN_WORD, 1'b0, n);
    issue(14'h0000, 1'b0, n);
    check(n, 1'b1);
    issue(14'h3455, 1'b0, n);
    check({cls, lit8}, {CDS_CLASS_LIT, 8'h55});
    issue(14'h0000, 1'b0, n);
    check(n, 1'b1);
  endtask : t_fields

  task automatic t_sleep(input cds_osc_type m, input logic g);
    logic n;
    int w0, v0, c;
    osc_mode = m;
    global_irq_enable = g;
    w0 = wdt_cnt;
    issue(`CDS_SLEEP_WORD, 1'b0, n);
    next_word = 14'h0000;
    check({slp, osc_on, to_n, pd_n}, 4'hA);
    check(16'(wdt_cnt - w0), 16'h0001);
    repeat (5) @(negedge ref_clk_in);
    irq = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    irq = 1'b0;
    check({slp, osc_on}, 2'b01);
    check({to_n, pd_n}, 2'b10);
    c = 2;
    while (phase !== 2'h1 && c < 1200) begin
      @(negedge ref_clk_in);
      c++;
    end
    // Two negedges pass between raising irq and seeing phase 1 on top of the start-up wait
    check(16'(c), (m == CDS_OSC_RC) ? 16'h0002 : 16'(`CDS_OST_CYCLES + 2));
    v0 = vec_cnt;
    issue(14'h0000, 1'b0, n);
    check(16'(vec_cnt - v0), 16'(g));
    issue(14'h0000, 1'b0, n);
    check(16'(vec_cnt - v0), 16'(g));
    check(vaddr, `CDS_IRQ_VECTOR);
  endtask : t_sleep

  task automatic t_race;
    logic n;
    int w0;
    global_irq_enable = 1'b0;
    issue(`CDS_CLRWDT_WORD, 1'b0, n);
    check({to_n, pd_n}, 2'b11);
    irq = 1'b1;
    w0 = wdt_cnt;
    issue(`CDS_SLEEP_WORD, 1'b0, n);
    next_word = 14'h0000;
    repeat (4) @(negedge ref_clk_in);
    check({slp, osc_on, to_n, pd_n}, 4'h7);
    check(16'(wdt_cnt - w0), 16'h0000);
    irq = 1'b0;
  endtask : t_race

  // Reset in mid-run, taken while in standby
  task automatic t_reset;
    logic n;
    issue(`CDS_SLEEP_WORD, 1'b0, n);
    next_word = 14'h0000;
    check(slp, 1'b1);
    reset_n_in = 1'b0;
    @(negedge ref_clk_in);
    check({slp, osc_on, to_n, pd_n, phase}, 6'h1C);
    reset_n_in = 1'b1;
    issue(14'h0000, 1'b0, n);
    check(n, 1'b0);
  endtask : t_reset

  initial begin
    #2_000_000;
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    t_phase();
    t_fields();
    t_sleep(CDS_OSC_LP, 1'b1);
    t_sleep(CDS_OSC_XT, 1'b0);
    t_sleep(CDS_OSC_HS, 1'b1);
    t_sleep(CDS_OSC_RC, 1'b0);
    t_race();
    t_reset();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
